// >>> hw/calu_pkg.sv
package calu_pkg;
    // operation codes presented on op_code
    typedef enum logic [3:0] {
        CALU_OP_ADD_WITH_CARRY    = 4'h0,
        CALU_OP_MINUS             = 4'h1,
        CALU_OP_MINUS_WITH_BORROW = 4'h2,
        CALU_OP_AND               = 4'h3,
        CALU_OP_OR                = 4'h4,
        CALU_OP_XOR               = 4'h5,
        CALU_OP_COMPARE_BYTE      = 4'h6,
        CALU_OP_COMPARE_ZERO      = 4'h7,
        CALU_OP_COMPARE_X_INDEXED = 4'h8,
        CALU_OP_WORD_ADD          = 4'h9,
        CALU_OP_WORD_MINUS        = 4'hA,
        CALU_OP_COMPARE_WORD      = 4'hB,
        CALU_OP_UNSIGNED_MULTIPLY = 4'hC
    } calu_op_type;

    // sequencer states, gray along idle -> busy -> done
    typedef enum logic [1:0] {
        CALU_ST_IDLE = 2'b00,
        CALU_ST_BUSY = 2'b01,
        CALU_ST_DONE = 2'b11
    } calu_state_type;

    // cycle costs in cpu clocks
    localparam logic [3:0] CALU_CYC_BASE      = 4'h1;
    localparam logic [3:0] CALU_CYC_SEG       = 4'h2;
    localparam logic [3:0] CALU_CYC_PROG      = 4'h4;
    localparam logic [3:0] CALU_CYC_PROG_SEG  = 4'h5;
    localparam logic [3:0] CALU_CYC_RAM_EXTRA = 4'h3;
    // reset values; CALU_ZERO_BYTE is the compare-zero operand
    localparam logic [15:0] CALU_PAIR_RESET   = 16'h0000;
    localparam logic [7:0]  CALU_BYTE_RESET   = 8'h00;
    localparam logic [3:0]  CALU_SEG_RESET    = 4'h0;
    localparam logic [7:0]  CALU_ZERO_BYTE    = 8'h00;
endpackage

// >>> hw/calu_core.sv
`timescale 1ns/100ps
// combinational arithmetic/logic core; flags from the selected width
module calu_core
    import calu_pkg::*;
(
    input  wire calu_op_type op_code,
    input  wire logic [15:0] dst_word,
    input  wire logic [15:0] src_word,
    input  wire logic        carry_in,
    output logic      [15:0] result,
    output logic             zero_out,
    output logic             aux_out,
    output logic             carry_out,
    output logic             writes_back,
    output logic             flags_arith,
    output logic             is_word
);
    logic [8:0]  sum8;
    logic [4:0]  nib;
    logic [16:0] sum16;
    logic [12:0] low12;
    logic [7:0]  a8;
    logic [7:0]  b8;

    // one adder per width; subtraction done as a borrow-out difference
    always_comb begin
        a8          = dst_word[7:0];
        b8          = src_word[7:0];
        sum8        = 9'h000;
        nib         = 5'h00;
        sum16       = 17'h00000;
        low12       = 13'h0000;
        result      = 16'h0000;
        writes_back = 1'b1;
        flags_arith = 1'b1;
        is_word     = 1'b0;
        case (op_code)
            CALU_OP_ADD_WITH_CARRY: begin // see RULE_01
                sum8 = {1'b0, a8} + {1'b0, b8} + {8'h00, carry_in};
                nib  = {1'b0, a8[3:0]} + {1'b0, b8[3:0]} + {4'h0, carry_in};
            end
            CALU_OP_MINUS: begin // see RULE_03
                sum8 = {1'b0, a8} - {1'b0, b8};
                nib  = {1'b0, a8[3:0]} - {1'b0, b8[3:0]};
            end
            CALU_OP_MINUS_WITH_BORROW: begin // see RULE_04
                sum8 = {1'b0, a8} - {1'b0, b8} - {8'h00, carry_in};
                nib  = {1'b0, a8[3:0]} - {1'b0, b8[3:0]} - {4'h0, carry_in};
            end
            CALU_OP_AND: begin // see RULE_05
                sum8        = {1'b0, a8 & b8};
                flags_arith = 1'b0;
            end
            CALU_OP_OR: begin // see RULE_06
                sum8        = {1'b0, a8 | b8};
                flags_arith = 1'b0;
            end
            CALU_OP_XOR: begin // see RULE_07
                sum8        = {1'b0, a8 ^ b8};
                flags_arith = 1'b0;
            end
            CALU_OP_COMPARE_BYTE,
            CALU_OP_COMPARE_X_INDEXED: begin // see RULE_08, see RULE_09
                sum8        = {1'b0, a8} - {1'b0, b8};
                nib         = {1'b0, a8[3:0]} - {1'b0, b8[3:0]};
                writes_back = 1'b0;
            end
            CALU_OP_COMPARE_ZERO: begin // see RULE_09
                sum8        = {1'b0, a8} - {1'b0, CALU_ZERO_BYTE};
                nib         = {1'b0, a8[3:0]};
                writes_back = 1'b0;
            end
            CALU_OP_WORD_ADD: begin // see RULE_10
                is_word = 1'b1;
                sum16   = {1'b0, dst_word} + {1'b0, src_word};
                low12   = {1'b0, dst_word[11:0]} + {1'b0, src_word[11:0]};
            end
            CALU_OP_WORD_MINUS,
            CALU_OP_COMPARE_WORD: begin // see RULE_12, see RULE_13
                is_word     = 1'b1;
                sum16       = {1'b0, dst_word} - {1'b0, src_word};
                low12       = {1'b0, dst_word[11:0]} - {1'b0, src_word[11:0]};
                writes_back = (op_code == CALU_OP_WORD_MINUS);
            end
            CALU_OP_UNSIGNED_MULTIPLY: begin // see RULE_14
                is_word     = 1'b1;
                sum16       = {1'b0, 16'(a8) * 16'(src_word[7:0])};
                flags_arith = 1'b0;
            end
            default: begin
                writes_back = 1'b0;
                flags_arith = 1'b0;
            end
        endcase
        result = is_word ? sum16[15:0] : {8'h00, sum8[7:0]};
    end

    // zero from result width; aux from bit 3 (byte) or bit 11 (word)
    assign zero_out  = is_word ? (sum16[15:0] == 16'h0000)
                               : (sum8[7:0] == 8'h00); // see RULE_20
    assign aux_out   = is_word ? low12[12] : nib[4]; // see RULE_20
    assign carry_out = is_word ? sum16[16] : sum8[8];
endmodule // calu_core

// >>> hw/calu_unit.sv
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
// What this block does
// RULE_01 - add with carry updates Z, AC, CY
// RULE_02 - register destination add stores sum there
// RULE_03 - subtract from accumulator, carry is borrow
// RULE_04 - subtract source and carry from destination
// RULE_05 - AND stores result, updates zero only
// RULE_06 - OR stores result, updates zero only
// RULE_07 - XOR stores into accumulator, zero only
// RULE_08 - byte compare sets flags, writes nothing
// RULE_09 - index and zero compares only flag
// RULE_10 - word add into accumulator pair
// RULE_11 - word add may double the pair
// RULE_12 - word subtract into accumulator pair
// RULE_13 - word compare leaves pair unchanged
// RULE_14 - multiply A by X into pair
// RULE_15 - one clock base, two with prefix
// RULE_16 - program memory operand: four or five
// RULE_17 - counts are cpu clock periods
// RULE_18 - ram fetch costs at most twice plus three
// RULE_19 - extra segment forms upper address bits
// RULE_20 - zero on zero result, aux bit three (bit eleven for word ops)
module calu_unit
    import calu_pkg::*;
#(
    parameter int SEG_WIDTH = 4
)(
    input  wire logic                 ref_clk,
    input  wire logic                 rst_n,
    input  wire logic                 op_start,
    input  wire calu_op_type          op_code,
    input  wire logic                 dst_is_pair,
    input  wire logic [15:0]          src_word,
    input  wire logic                 src_is_pair,
    input  wire logic                 dst_is_reg,
    input  wire logic [7:0]           reg_operand,
    input  wire logic [7:0]           x_operand,
    input  wire logic [15:0]          operand_addr,
    input  wire logic                 use_extra_segment,
    input  wire logic                 short_immediate,
    input  wire logic                 from_program_mem,
    input  wire logic                 fetch_from_ram,
    input  wire logic                 seg_load,
    input  wire logic [SEG_WIDTH-1:0] seg_value,
    output logic [15:0]               accumulator_pair,
    output logic [7:0]                reg_result,
    output logic                      reg_write,
    output logic [SEG_WIDTH+15:0]     full_addr,
    output logic                      zero_flag,
    output logic                      aux_carry_flag,
    output logic                      carry_flag,
    output logic                      op_busy,
    output logic                      op_done,
    output logic [3:0]                op_cycles
);
    // ==========================================================
    // state
    // ==========================================================
    calu_state_type         state_q, state_d;
    logic [15:0]            acc_q, acc_d;
    logic [7:0]             reg_q, reg_d;
    logic                   regw_q, regw_d;
    logic                   z_q, z_d, ac_q, ac_d, cy_q, cy_d;
    logic [SEG_WIDTH-1:0]   seg_q, seg_d;
    logic [SEG_WIDTH+15:0]  addr_q, addr_d;
    logic [3:0]             cnt_q, cnt_d;
    logic [3:0]             cost_q, cost_d;
    logic                   done_q, done_d;
    logic [3:0]             base_cost;
    logic [3:0]             base_cost_past;
    logic                   busy_q, busy_d;

    // ==========================================================
    // datapath
    // ==========================================================
    logic [15:0] dst_w, src_w, res;
    logic        c_z, c_ac, c_cy, c_wb, c_ar, c_word;

    // operand routing; x register acts as destination for index compare
    always_comb begin
        if (op_code == CALU_OP_COMPARE_X_INDEXED) begin
            dst_w = {8'h00, x_operand}; // see RULE_09
        end else if (dst_is_reg) begin
            dst_w = {8'h00, reg_operand}; // see RULE_02
        end else begin
            dst_w = acc_q;
        end
        if (src_is_pair) begin
            src_w = acc_q; // see RULE_11
        end else if (op_code == CALU_OP_UNSIGNED_MULTIPLY) begin
            src_w = {8'h00, x_operand}; // see RULE_14
        end else if (dst_is_reg) begin
            src_w = {8'h00, acc_q[7:0]}; // see RULE_02
        end else begin
            src_w = src_word;
        end
    end

    calu_core u_core (
        .op_code     (op_code),
        .dst_word    (dst_w),
        .src_word    (src_w),
        .carry_in    (cy_q),
        .result      (res),
        .zero_out    (c_z),
        .aux_out     (c_ac),
        .carry_out   (c_cy),
        .writes_back (c_wb),
        .flags_arith (c_ar),
        .is_word     (c_word)
    );

    // cost: prefix or immediate-to-short adds a clock; program memory 4/5
    always_comb begin
        if (from_program_mem) begin // see RULE_16
            base_cost = use_extra_segment ? CALU_CYC_PROG_SEG
                                          : CALU_CYC_PROG;
        end else if (use_extra_segment || short_immediate) begin
            base_cost = CALU_CYC_SEG; // see RULE_15
        end else begin
            base_cost = CALU_CYC_BASE; // see RULE_15
        end
    end

    // ==========================================================
    // sequencer: one count per cpu clock period
    // ==========================================================
    always_comb begin
        state_d = state_q;
        acc_d   = acc_q;
        reg_d   = reg_q;
        regw_d  = 1'b0;
        z_d     = z_q;
        ac_d    = ac_q;
        cy_d    = cy_q;
        seg_d   = seg_load ? seg_value : seg_q;
        addr_d  = addr_q;
        cnt_d   = cnt_q;
        cost_d  = cost_q;
        done_d  = 1'b0;
        case (state_q)
            CALU_ST_IDLE: begin
                if (op_start) begin
                    // ram fetch slowest case: twice plus three
                    cost_d = fetch_from_ram
                           ? 4'((base_cost << 1) + CALU_CYC_RAM_EXTRA)
                           : base_cost; // see RULE_18
                    cnt_d  = 4'h1; // see RULE_17
                    addr_d = {use_extra_segment ? seg_q
                                                : {SEG_WIDTH{1'b0}},
                              operand_addr}; // see RULE_19
                    if (op_code != CALU_OP_UNSIGNED_MULTIPLY) begin
                        z_d = c_z; // see RULE_20
                    end
                    if (c_ar) begin
                        ac_d = c_ac;
                        cy_d = c_cy; // see RULE_01
                    end
                    if (c_wb) begin
                        if (dst_is_reg && !c_word) begin
                            reg_d  = res[7:0]; // see RULE_02
                            regw_d = 1'b1;
                        end else if (c_word) begin
                            acc_d = res; // see RULE_10
                        end else begin
                            acc_d = {acc_q[15:8], res[7:0]}; // see RULE_03
                        end
                    end
                    if (cost_d == CALU_CYC_BASE) begin
                        state_d = CALU_ST_DONE;
                        done_d  = 1'b1;
                    end else begin
                        state_d = CALU_ST_BUSY;
                    end
                end
            end
            CALU_ST_BUSY: begin
                cnt_d = 4'(cnt_q + 4'h1);
                if (cnt_d == cost_q) begin
                    state_d = CALU_ST_DONE;
                    done_d  = 1'b1;
                end
            end
            CALU_ST_DONE: begin
                state_d = CALU_ST_IDLE;
            end
            default: begin
                state_d = CALU_ST_IDLE;
            end
        endcase
        busy_d  = (state_d == CALU_ST_BUSY);
    end

    // register all state; dst_is_pair is informational for the core path
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= CALU_ST_IDLE;
            acc_q   <= CALU_PAIR_RESET;
            reg_q   <= CALU_BYTE_RESET;
            regw_q  <= 1'b0;
            z_q     <= 1'b0;
            ac_q    <= 1'b0;
            cy_q    <= 1'b0;
            seg_q   <= SEG_WIDTH'(CALU_SEG_RESET);
            addr_q  <= '0;
            cnt_q   <= 4'h0;
            cost_q  <= 4'h0;
            done_q  <= 1'b0;
            busy_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            acc_q   <= acc_d;
            reg_q   <= reg_d;
            regw_q  <= regw_d;
            z_q     <= z_d;
            ac_q    <= ac_d;
            cy_q    <= cy_d;
            seg_q   <= seg_d;
            addr_q  <= addr_d;
            cnt_q   <= cnt_d;
            cost_q  <= cost_d;
            done_q  <= done_d;
            busy_q  <= busy_d;
        end
    end

    // outputs straight from flops
    assign accumulator_pair = acc_q;
    assign reg_result       = reg_q;
    assign reg_write        = regw_q;
    assign full_addr        = addr_q;
    assign zero_flag        = z_q;
    assign aux_carry_flag   = ac_q;
    assign carry_flag       = cy_q;
    assign op_busy          = busy_q;
    assign op_done          = done_q;
    assign op_cycles        = cost_q;

    // ==========================================================
    // checks
    // ==========================================================
    a_logic_keeps_carry: assert property ( // see RULE_05
        @(posedge ref_clk) disable iff (!rst_n)
        (state_q == CALU_ST_IDLE && op_start &&
         (op_code == CALU_OP_AND || op_code == CALU_OP_OR ||
          op_code == CALU_OP_XOR)) |=> $stable(cy_q) && $stable(ac_q))
        else $error("logic op changed carry flags");
    a_compare_no_write: assert property ( // see RULE_08
        @(posedge ref_clk) disable iff (!rst_n)
        (state_q == CALU_ST_IDLE && op_start &&
         (op_code == CALU_OP_COMPARE_BYTE ||
          op_code == CALU_OP_COMPARE_WORD)) |=> $stable(acc_q) && !regw_q)
        else $error("compare wrote a result");
    a_zero_matches_acc: assert property ( // see RULE_20
        @(posedge ref_clk) disable iff (!rst_n)
        (state_q == CALU_ST_IDLE && op_start &&
         op_code == CALU_OP_WORD_ADD && !src_is_pair)
        |=> z_q == (acc_q == 16'h0000))
        else $error("zero flag disagrees with word sum");
    a_multiply_product: assert property ( // see RULE_14
        @(posedge ref_clk) disable iff (!rst_n)
        (state_q == CALU_ST_IDLE && op_start &&
         op_code == CALU_OP_UNSIGNED_MULTIPLY)
        |=> acc_q == $past(acc_q[7:0]) * $past(x_operand))
        else $error("multiply product wrong");
    a_base_one_clock: assert property ( // see RULE_15
        @(posedge ref_clk) disable iff (!rst_n)
        (state_q == CALU_ST_IDLE && op_start && !from_program_mem &&
         !use_extra_segment && !short_immediate && !fetch_from_ram)
        |=> done_q)
        else $error("base form not done in one clock");
    a_prog_seg_five: assert property ( // see RULE_16
        @(posedge ref_clk) disable iff (!rst_n)
        (state_q == CALU_ST_IDLE && op_start && from_program_mem &&
         use_extra_segment && !fetch_from_ram)
        |=> !done_q [*4] ##1 done_q)
        else $error("program memory prefixed form not five clocks");
    a_ram_fetch_cost: assert property ( // see RULE_18
        @(posedge ref_clk) disable iff (!rst_n)
        (state_q == CALU_ST_IDLE && op_start && fetch_from_ram)
        |=> cost_q <= 4'((base_cost_past << 1) + CALU_CYC_RAM_EXTRA))
        else $error("ram fetch cost exceeds bound");
    a_segment_address: assert property ( // see RULE_19
        @(posedge ref_clk) disable iff (!rst_n)
        (state_q == CALU_ST_IDLE && op_start && use_extra_segment)
        |=> addr_q == {$past(seg_q), $past(operand_addr)})
        else $error("segment not prefixed to address");

    a_mul_flags_kept: assert property ( // see RULE_14
        @(posedge ref_clk) disable iff (!rst_n)
        state_q == CALU_ST_IDLE && op_start && c_word && !c_ar
        |=> $stable({z_q, ac_q, cy_q}))
        else $error("multiply changed flags");
    a_busy_refuses: assert property ( // see RULE_15
        @(posedge ref_clk) disable iff (!rst_n)
        state_q != CALU_ST_IDLE && op_start |=> $stable(acc_q))
        else $error("start taken while busy");

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            base_cost_past <= 4'h0;
        end else begin
            base_cost_past <= base_cost;
        end
    end
endmodule // calu_unit

// >>> tb/calu_mem_model.sv
`timescale 1ns/100ps
// =====================================================================
// far side: operand memory, general register and X register
module calu_mem_model (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] operand_addr,
    input  wire logic [7:0]  reg_result,
    input  wire logic        reg_write,
    output logic      [15:0] src_word,
    output logic      [7:0]  reg_operand,
    output logic      [7:0]  x_operand
);
    logic [15:0] mem [0:255];
    logic [7:0]  gen_reg;
    logic [7:0]  x_reg;

    // only the low address byte is decoded; the bench aims there
    assign src_word    = mem[operand_addr[7:0]];
    assign reg_operand = gen_reg;
    assign x_operand   = x_reg;

    // general register takes the register-form sum when strobed
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gen_reg <= 8'h00;
        end else if (reg_write) begin
            gen_reg <= reg_result;
        end
    end

    // known contents so a stray read never returns unknowns
    initial begin
        x_reg = 8'h00;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'h0000;
        end
    end
endmodule // calu_mem_model

// >>> tb/calu_unit_tb.sv
`timescale 1ns/100ps
module calu_unit_tb;
    import calu_pkg::*;
    logic        ref_clk, rst_n, op_start, dst_is_pair, src_is_pair;
    logic        dst_is_reg, use_extra_segment, short_immediate;
    logic        from_program_mem, fetch_from_ram, seg_load;
    calu_op_type op_code, op;
    logic [15:0] src_word, operand_addr, accumulator_pair, e_acc;
    logic [7:0]  reg_operand, x_operand, reg_result, e_reg;
    logic [3:0]  seg_value, op_cycles, e_seg, m;
    logic [19:0] full_addr;
    logic        reg_write, zero_flag, aux_carry_flag, carry_flag;
    logic        op_busy, op_done, e_z, e_ac, e_cy, e_wr, s_reg, s_pair;
    int          error_cnt, num_checks;

    calu_unit #(.SEG_WIDTH(4)) dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .op_start(op_start),
        .op_code(op_code), .dst_is_pair(dst_is_pair),
        .src_word(src_word), .src_is_pair(src_is_pair),
        .dst_is_reg(dst_is_reg), .reg_operand(reg_operand),
        .x_operand(x_operand), .operand_addr(operand_addr),
        .use_extra_segment(use_extra_segment),
        .short_immediate(short_immediate),
        .from_program_mem(from_program_mem),
        .fetch_from_ram(fetch_from_ram), .seg_load(seg_load),
        .seg_value(seg_value), .accumulator_pair(accumulator_pair),
        .reg_result(reg_result), .reg_write(reg_write),
        .full_addr(full_addr), .zero_flag(zero_flag),
        .aux_carry_flag(aux_carry_flag), .carry_flag(carry_flag),
        .op_busy(op_busy), .op_done(op_done), .op_cycles(op_cycles)
    );
    calu_mem_model model_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .operand_addr(operand_addr),
        .reg_result(reg_result), .reg_write(reg_write),
        .src_word(src_word), .reg_operand(reg_operand),
        .x_operand(x_operand)
    );

    // =================================================================
    // helpers
    task automatic chk(input logic ok, input string what);
        num_checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("BAD t=%0t %s", $time, what);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // mode bits: 0 segment prefix, 1 short immediate, 2 program memory,
    // 3 fetched from ram
    function automatic logic [3:0] cost_of(input logic [3:0] md);
        logic [3:0] b;
        if (md[2]) b = md[0] ? CALU_CYC_PROG_SEG : CALU_CYC_PROG;
        else b = (md[0] | md[1]) ? CALU_CYC_SEG : CALU_CYC_BASE;
        cost_of = md[3] ? 4'(2 * b + CALU_CYC_RAM_EXTRA) : b;
    endfunction

    // reference arithmetic kept in plain integers
    task automatic predict(input calu_op_type o, input logic [15:0] s);
        int a, b, c, r, md, full;
        logic wide;
        wide = o inside {CALU_OP_WORD_ADD, CALU_OP_WORD_MINUS,
                         CALU_OP_COMPARE_WORD};
        md = wide ? 4096 : 16;
        full = wide ? 65536 : 256;
        a = s_reg ? model_u.gen_reg : e_acc[7:0];
        b = s_reg ? e_acc[7:0] : s[7:0];
        c = (o == CALU_OP_ADD_WITH_CARRY ||
             o == CALU_OP_MINUS_WITH_BORROW) ? e_cy : 0;
        if (o == CALU_OP_COMPARE_X_INDEXED) a = model_u.x_reg;
        if (wide) begin
            a = e_acc;
            b = s_pair ? e_acc : s;
        end
        e_wr = s_reg && o == CALU_OP_ADD_WITH_CARRY;
        case (o)
            CALU_OP_ADD_WITH_CARRY, CALU_OP_WORD_ADD: begin
                r = a + b + c;
                e_ac = (a % md + b % md + c) >= md;
                e_cy = r >= full;
            end
            CALU_OP_AND:          r = a & b;
            CALU_OP_OR:           r = a | b;
            CALU_OP_XOR:          r = a ^ b;
            CALU_OP_COMPARE_ZERO: begin
                r = a;
                e_ac = 1'b0;
                e_cy = 1'b0;
            end
            CALU_OP_UNSIGNED_MULTIPLY: r = e_acc[7:0] * model_u.x_reg;
            default: begin
                r = a - b - c;
                e_ac = (a % md) < (b % md + c);
                e_cy = r < 0;
            end
        endcase
        if (o != CALU_OP_UNSIGNED_MULTIPLY) begin
            e_z = wide ? (r[15:0] == 16'h0000) : (r[7:0] == 8'h00);
        end
        if (o <= CALU_OP_XOR && s_reg) e_reg = r[7:0];
        else if (o <= CALU_OP_XOR) e_acc[7:0] = r[7:0];
        if (o inside {CALU_OP_WORD_ADD, CALU_OP_WORD_MINUS,
                      CALU_OP_UNSIGNED_MULTIPLY}) e_acc = r[15:0];
    endtask

    task automatic load_seg(input logic [3:0] v);
        @(posedge ref_clk);
        seg_load <= 1'b1;
        seg_value <= v;
        @(posedge ref_clk);
        seg_load <= 1'b0;
        e_seg = v;
    endtask

    // one operation; hold2 keeps the start high one extra edge
    task automatic do_op(input calu_op_type o, input logic [15:0] ad,
                         input logic [15:0] d, input logic [3:0] md,
                         input logic hold2);
        int k;
        logic [3:0] cost;
        logic busy1, wr1;
        if (o == CALU_OP_COMPARE_ZERO) d[7:0] = e_acc[7:0];
        model_u.mem[ad[7:0]] = d;
        cost = cost_of(md);
        predict(o, d);
        @(posedge ref_clk);
        {op_start, op_code, operand_addr} <= {1'b1, o, ad};
        {fetch_from_ram, from_program_mem} <= md[3:2];
        {short_immediate, use_extra_segment} <= md[1:0];
        {src_is_pair, dst_is_reg} <= {s_pair, s_reg};
        @(posedge ref_clk);
        if (!hold2) op_start <= 1'b0;
        #1;
        {busy1, wr1, k} = {op_busy, reg_write, 32'd1};
        while (op_done !== 1'b1 && k < 20) begin
            @(posedge ref_clk);
            op_start <= 1'b0;
            #1;
            k++;
        end
        if (op_done !== 1'b1) begin
            chk(1'b0, "no completion");
            tally_and_finish();
        end
        chk(k == cost, "done timing");
        chk(op_cycles === cost, "cycle cost");
        chk(busy1 === (cost > 4'h1), "busy level");
        chk(accumulator_pair === e_acc, "pair");
        chk({zero_flag, aux_carry_flag, carry_flag} === {e_z, e_ac, e_cy},
            "flags");
        chk(wr1 === e_wr, "reg strobe");
        chk(!e_wr || reg_result === e_reg, "reg value");
        chk(full_addr === {(md[0] ? e_seg : 4'h0), ad}, "addr");
        @(posedge ref_clk);
        op_start <= 1'b0;
        #1;
        chk(op_done === 1'b0, "start taken twice");
    endtask

    task automatic clear_exp();
        {e_acc, e_z, e_ac, e_cy, e_seg, s_reg, s_pair} = '0;
    endtask

    // =================================================================
    // clock and main sequence
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        {op_start, src_is_pair, dst_is_reg, use_extra_segment} = '0;
        {short_immediate, from_program_mem, fetch_from_ram} = '0;
        {seg_load, seg_value, operand_addr, rst_n} = '0;
        dst_is_pair = 1'b1; // hint only
        op_code = CALU_OP_AND;
        {error_cnt, num_checks} = '0;
        clear_exp();
        void'($urandom(15259));
        repeat (5) @(posedge ref_clk);
        #1;
        chk({accumulator_pair, reg_write, full_addr, zero_flag, op_busy,
             aux_carry_flag, carry_flag, op_done, op_cycles} === '0, "rst");
        @(posedge ref_clk);
        rst_n <= 1'b1;
        $display("test reset done");
        load_seg(4'hA);
        model_u.x_reg = 8'hFF;
        model_u.gen_reg = 8'hF0;
        do_op(CALU_OP_AND, 16'h0, 16'h0, 4'h0, 1'b0);
        do_op(CALU_OP_WORD_MINUS, 16'h10, 16'h1, 4'h1, 1'b0);
        do_op(CALU_OP_WORD_ADD, 16'h20, 16'h1, 4'h4, 1'b0);
        do_op(CALU_OP_ADD_WITH_CARRY, 16'h30, 16'hF, 4'h5, 1'b0);
        do_op(CALU_OP_COMPARE_BYTE, 16'h40, 16'h10, 4'h2, 1'b1);
        do_op(CALU_OP_MINUS_WITH_BORROW, 16'h50, 16'h11, 4'hD, 1'b0);
        do_op(CALU_OP_UNSIGNED_MULTIPLY, 16'h60, 16'h0, 4'h8, 1'b1);
        do_op(CALU_OP_COMPARE_ZERO, 16'h70, 16'h0, 4'h0, 1'b0);
        s_reg = 1'b1;
        do_op(CALU_OP_ADD_WITH_CARRY, 16'h80, 16'h0, 4'h0, 1'b0);
        {s_reg, s_pair} = 2'b01;
        do_op(CALU_OP_WORD_ADD, 16'h90, 16'h1234, 4'h0, 1'b1);
        s_pair = 1'b0;
        $display("test corners done");
        for (int i = 0; i < 78; i++) begin
            if (i % 10 == 0) load_seg(4'($urandom));
            model_u.gen_reg = 8'($urandom);
            model_u.x_reg = 8'($urandom);
            op = calu_op_type'(i % 13);
            s_reg = (op == CALU_OP_ADD_WITH_CARRY) && $urandom_range(1);
            s_pair = (op == CALU_OP_WORD_ADD) && $urandom_range(1);
            m = 4'($urandom);
            if (m[2]) m[1] = 1'b0;
            do_op(op, 16'($urandom), 16'($urandom), m,
                  $urandom_range(4) == 0);
        end
        $display("test random done");
        @(posedge ref_clk);
        rst_n <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk({accumulator_pair, full_addr, zero_flag, carry_flag,
             aux_carry_flag, op_busy, op_done} === '0, "second rst");
        clear_exp();
        @(posedge ref_clk);
        rst_n <= 1'b1;
        do_op(CALU_OP_XOR, 16'hA0, 16'hC3, 4'h3, 1'b0);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule // calu_unit_tb
